// ==== verilog/tmr8_top.sv ====
// 8-bit timer with compare unit, waveform generator and APB registers
`timescale 1ns/1ps
`default_nettype none
`include "tmr8_defs.svh"

module tmr8_top
    import tmr8_pkg::*;
(
    input wire logic pclk, // I/O clock
    input wire logic presetn, // Async reset, active low
    input wire logic psel, // APB select
    input wire logic penable, // APB enable
    input wire logic pwrite, // APB direction
    input wire logic [11:0] paddr, // APB byte address
    input wire logic [31:0] pwdata, // APB write data
    output logic [31:0] prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr, // APB error
    input wire logic ovf_ack, // Overflow interrupt serviced
    input wire logic cmp_ack, // Compare interrupt serviced
    output logic ovf_flag, // Overflow flag
    output logic cmp_flag, // Compare match flag
    output logic pin_out, // Compare pin output value
    output logic pin_oe // Compare pin output enable
);

    // ------------------------------------------------------------
    // Register bus
    // ------------------------------------------------------------
    tmr8_ctrl_t ctrl_r;
    logic [7:0] count_value_r;
    logic [7:0] compare_buf_r;
    logic [7:0] compare_act_r;
    logic overflow_flag_r;
    logic compare_match_flag_r;
    logic port_val_r;
    logic port_dir_r;
    logic compare_output_bit_r;
    logic pin_out_r;
    logic pin_oe_r;
    logic [31:0] prdata_r;

    wire setup = psel && !penable;
    wire wr = psel && penable && pwrite;
    wire hit_ctrl = paddr == `TMR8_OFF_CTRL;
    wire hit_count = paddr == `TMR8_OFF_COUNT;
    wire hit_compare = paddr == `TMR8_OFF_COMPARE;
    wire hit_flags = paddr == `TMR8_OFF_FLAGS;
    wire hit_port = paddr == `TMR8_OFF_PORT;
    wire mapped = hit_ctrl || hit_count || hit_compare || hit_flags || hit_port;
    wire wr_ctrl = wr && hit_ctrl;
    wire wr_count = wr && hit_count;
    wire wr_compare = wr && hit_compare;
    wire wr_flags = wr && hit_flags;
    wire wr_port = wr && hit_port;
    tmr8_ctrl_t wctrl;
    assign wctrl = tmr8_ctrl_t'(pwdata[7:0]);

    logic [31:0] rd_mux;
    always_comb begin
        if (hit_ctrl) begin
            rd_mux = {24'h000000, 1'b0, ctrl_r[6:0]};
        end else if (hit_count) begin
            rd_mux = {24'h000000, count_value_r};
        end else if (hit_compare) begin
            rd_mux = {24'h000000, compare_buf_r};
        end else if (hit_flags) begin
            rd_mux = {30'h0, compare_match_flag_r, overflow_flag_r};
        end else if (hit_port) begin
            rd_mux = {30'h0, port_dir_r, port_val_r};
        end else begin
            rd_mux = 32'h00000000;
        end
    end

    assign pready = 1'b1;
    assign pslverr = psel && penable && !mapped;
    assign prdata = prdata_r;

    // ------------------------------------------------------------
    // Counter
    // ------------------------------------------------------------
    logic tick;
    tmr8_prescaler u_prescaler (
        .pclk(pclk),
        .presetn(presetn),
        .clk_sel(ctrl_r.clk_sel),
        .tick(tick)
    );

    tmr8_mode_t mode;
    assign mode = tmr8_mode_t'(ctrl_r.waveform_mode_select);
    wire [1:0] action = ctrl_r.output_action_select;
    wire is_fast = mode == TMR8_MODE_FAST_PWM;
    wire is_ctc = mode == TMR8_MODE_CLEAR_ON_MATCH;
    wire is_max = count_value_r == `TMR8_MAX;
    // Fast PWM compares against the active copy only, loaded from the buffer at wrap
    wire [7:0] compare_cmp = is_fast ? compare_act_r : compare_buf_r;
    wire match = tick && (count_value_r == compare_cmp);
    wire ctc_clear = is_ctc && match;
    wire wrap = tick && is_max;
    wire [7:0] count_inc = count_value_r + `TMR8_ONE;
    wire [7:0] count_step = ctc_clear ? `TMR8_BOTTOM : count_inc;
    wire [7:0] count_nxt = wr_count ? pwdata[7:0] : (tick ? count_step : count_value_r);

    // Overflow timing depends on mode
    wire ovf_set = is_fast ? (tick && count_inc == `TMR8_MAX) : wrap;
    wire cmp_set = match;
    wire ovf_clr = ovf_ack || (wr_flags && pwdata[`TMR8_FLAG_OVF]);
    wire cmp_clr = cmp_ack || (wr_flags && pwdata[`TMR8_FLAG_CMP]);
    // Set wins over clear
    wire ovf_nxt = ovf_set || (overflow_flag_r && !ovf_clr);
    wire cmp_nxt = cmp_set || (compare_match_flag_r && !cmp_clr);

    // ------------------------------------------------------------
    // Waveform generator
    // ------------------------------------------------------------
    function automatic logic apply_action(input logic [1:0] act, input logic fast,
                                          input logic cur);
        logic res;
        res = cur;
        case (act)
            2'h1: res = !cur;
            2'h2: res = 1'b0;
            2'h3: res = 1'b1;
            default: res = cur;
        endcase
        if (fast && act == 2'h1) begin
            res = !cur;
        end
        return res;
    endfunction

    // Force only outside PWM; it presets the bit and raises no flag
    wire force_ok = wr_ctrl && wctrl.force_compare_strobe && !pwrite_pwm(wctrl);
    function automatic logic pwrite_pwm(input tmr8_ctrl_t c);
        return c.waveform_mode_select[0];
    endfunction

    logic oc_nxt;
    always_comb begin
        oc_nxt = compare_output_bit_r;
        if (force_ok) begin
            oc_nxt = apply_action(wctrl.output_action_select, 1'b0, compare_output_bit_r);
        end else if (match) begin
            // Action held in ctrl_r, so a value written in this cycle waits for the next match
            oc_nxt = apply_action(action, is_fast, compare_output_bit_r);
        end else if (is_fast && wrap && action[1]) begin
            oc_nxt = !action[0];
        end
    end

    // Nonzero action select takes the pin from the compare output bit, zero from the port value
    wire pin_val_nxt = (action != 2'h0) ? compare_output_bit_r : port_val_r;

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_r <= tmr8_ctrl_t'(`TMR8_CTRL_RST);
        end else if (wr_ctrl) begin
            ctrl_r <= {1'b0, wctrl[6:0]};
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_value_r <= `TMR8_COUNT_RST;
            overflow_flag_r <= 1'b0;
            compare_match_flag_r <= 1'b0;
        end else begin
            count_value_r <= count_nxt;
            overflow_flag_r <= ovf_nxt;
            compare_match_flag_r <= cmp_nxt;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            compare_buf_r <= `TMR8_COMPARE_RST;
            compare_act_r <= `TMR8_COMPARE_RST;
        end else begin
            if (wr_compare) begin
                compare_buf_r <= pwdata[7:0];
            end
            if (!is_fast || wrap) begin
                compare_act_r <= compare_buf_r;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            port_val_r <= 1'b0;
            port_dir_r <= 1'b0;
        end else if (wr_port) begin
            port_val_r <= pwdata[`TMR8_PORT_VAL];
            port_dir_r <= pwdata[`TMR8_PORT_DIR];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            compare_output_bit_r <= 1'b0;
            pin_out_r <= 1'b0;
            pin_oe_r <= 1'b0;
        end else begin
            compare_output_bit_r <= oc_nxt;
            pin_out_r <= pin_val_nxt;
            pin_oe_r <= port_dir_r;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_r <= 32'h00000000;
        end else if (setup) begin
            prdata_r <= rd_mux;
        end
    end

    assign ovf_flag = overflow_flag_r;
    assign cmp_flag = compare_match_flag_r;
    assign pin_out = pin_out_r;
    assign pin_oe = pin_oe_r;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    sequence seq_quiet;
        !wr_count && !force_ok;
    endsequence

    sequence seq_normal_top;
        mode == TMR8_MODE_NORMAL && wrap ##0 seq_quiet;
    endsequence

    sequence seq_ctc_match;
        is_ctc && match ##0 seq_quiet;
    endsequence

    sequence seq_fast_match;
        is_fast && match ##0 seq_quiet;
    endsequence

    AST_HOLD_ON_ZERO_ACTION: assert property (@(posedge pclk) disable iff (!presetn)
        match && action == 2'h0 && !force_ok |=> $stable(compare_output_bit_r))
        else $error("output bit changed with zero action");

    AST_NORMAL_WRAP: assert property (@(posedge pclk) disable iff (!presetn)
        seq_normal_top |=> count_value_r == `TMR8_BOTTOM)
        else $error("normal mode did not wrap to zero");

    AST_NORMAL_OVF: assert property (@(posedge pclk) disable iff (!presetn)
        seq_normal_top |=> overflow_flag_r && count_value_r == `TMR8_BOTTOM)
        else $error("overflow flag missing at wrap");

    AST_CTC_CLEAR_AND_FLAG: assert property (@(posedge pclk) disable iff (!presetn)
        seq_ctc_match |=> count_value_r == `TMR8_BOTTOM && compare_match_flag_r)
        else $error("clear-on-match did not clear or flag");

    AST_CTC_TOGGLE: assert property (@(posedge pclk) disable iff (!presetn)
        seq_ctc_match ##0 action == 2'h1 |=>
            compare_output_bit_r != $past(compare_output_bit_r))
        else $error("toggle missing on match");

    AST_FAST_RESTART: assert property (@(posedge pclk) disable iff (!presetn)
        is_fast && wrap && !wr_count |=> count_value_r == `TMR8_BOTTOM)
        else $error("fast pwm did not restart");

    AST_FAST_NONINV: assert property (@(posedge pclk) disable iff (!presetn)
        seq_fast_match ##0 action == 2'h2 |=> !compare_output_bit_r)
        else $error("non-inverted pwm not cleared on match");

    AST_FAST_INV_BOTTOM: assert property (@(posedge pclk) disable iff (!presetn)
        is_fast && wrap && !match && !force_ok && action == 2'h3 |=> !compare_output_bit_r)
        else $error("inverted pwm not cleared at bottom");

    AST_FORCE_SET: assert property (@(posedge pclk) disable iff (!presetn)
        force_ok && wctrl.output_action_select == 2'h3 |=> compare_output_bit_r)
        else $error("force strobe did not set output bit");

    AST_FORCE_NO_FLAG: assert property (@(posedge pclk) disable iff (!presetn)
        force_ok && !cmp_set && !compare_match_flag_r |=> !compare_match_flag_r)
        else $error("force strobe raised the compare flag");

    AST_PIN_GATE: assert property (@(posedge pclk) disable iff (!presetn)
        !port_dir_r && !wr_port |=> !pin_oe ##1 !pin_oe || $past(port_dir_r))
        else $error("pin enabled while direction is input");

    AST_FLAG_SET_WINS: assert property (@(posedge pclk) disable iff (!presetn)
        ovf_set && ovf_clr |=> overflow_flag_r)
        else $error("overflow set lost to clear");

    AST_CTC_OVF: assert property (@(posedge pclk) disable iff (!presetn)
        is_ctc && wrap |=> overflow_flag_r)
        else $error("overflow flag missing at wrap in clear-on-match");

    AST_FAST_OVF: assert property (@(posedge pclk) disable iff (!presetn)
        is_fast && tick && count_inc == `TMR8_MAX && !wr_count |=>
            overflow_flag_r && count_value_r == `TMR8_MAX)
        else $error("overflow flag missing at maximum in fast pwm");

    AST_FAST_BUFFER: assert property (@(posedge pclk) disable iff (!presetn)
        is_fast && !wrap |=> $stable(compare_act_r))
        else $error("active compare value changed away from bottom");

    AST_PIN_SOURCE: assert property (@(posedge pclk) disable iff (!presetn)
        action != 2'h0 |=> pin_out == $past(compare_output_bit_r))
        else $error("pin does not follow the output bit");

    AST_COUNT_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
        !tick && !wr_count |=> $stable(count_value_r))
        else $error("count moved without a timer tick");

endmodule
`default_nettype wire

// ==== verilog/tmr8_defs.svh ====
// Constants for the 8-bit waveform timer
`ifndef TMR8_DEFS_SVH
`define TMR8_DEFS_SVH

// Register byte offsets
`define TMR8_OFF_CTRL 12'h000
`define TMR8_OFF_COUNT 12'h004
`define TMR8_OFF_COMPARE 12'h008
`define TMR8_OFF_FLAGS 12'h00c
`define TMR8_OFF_PORT 12'h010

// Reset values
`define TMR8_CTRL_RST 8'h00
`define TMR8_COUNT_RST 8'h00
`define TMR8_COMPARE_RST 8'h00
`define TMR8_PORT_RST 2'h0

// Count limits
`define TMR8_MAX 8'hff
`define TMR8_BOTTOM 8'h00
`define TMR8_ONE 8'h01

// Flag bit positions
`define TMR8_FLAG_OVF 0
`define TMR8_FLAG_CMP 1
// Port register bit positions
`define TMR8_PORT_VAL 0
`define TMR8_PORT_DIR 1

// Prescaler masks on the free-running divider
`define TMR8_DIV8_MASK 10'h007
`define TMR8_DIV64_MASK 10'h03f
`define TMR8_DIV256_MASK 10'h0ff
`define TMR8_DIV1024_MASK 10'h3ff

`endif

// ==== verilog/tmr8_pkg.sv ====
// Types shared by the 8-bit waveform timer
package tmr8_pkg;

    typedef enum logic [1:0] {
        TMR8_MODE_NORMAL = 2'h0,
        TMR8_MODE_PHASE = 2'h1,
        TMR8_MODE_CLEAR_ON_MATCH = 2'h2,
        TMR8_MODE_FAST_PWM = 2'h3
    } tmr8_mode_t;

    typedef enum logic [2:0] {
        TMR8_CLK_STOP = 3'h0,
        TMR8_CLK_DIV1 = 3'h1,
        TMR8_CLK_DIV8 = 3'h2,
        TMR8_CLK_DIV64 = 3'h3,
        TMR8_CLK_DIV256 = 3'h4,
        TMR8_CLK_DIV1024 = 3'h5
    } tmr8_clk_sel_t;

    typedef struct packed {
        logic force_compare_strobe;
        logic [2:0] clk_sel;
        logic [1:0] output_action_select;
        logic [1:0] waveform_mode_select;
    } tmr8_ctrl_t;

endpackage

// ==== verilog/tmr8_prescaler.sv ====
// Prescaler producing the timer tick enable
`timescale 1ns/1ps
`default_nettype none
`include "tmr8_defs.svh"

module tmr8_prescaler
    import tmr8_pkg::*;
(
    input wire logic pclk, // I/O clock
    input wire logic presetn, // Async reset, active low
    input wire logic [2:0] clk_sel, // Division select
    output logic tick // Timer tick enable
);

    logic [9:0] div_r;
    logic tick_r;
    logic tick_nxt;

    always_comb begin
        case (tmr8_clk_sel_t'(clk_sel))
            TMR8_CLK_DIV1: tick_nxt = 1'b1;
            TMR8_CLK_DIV8: tick_nxt = (div_r & `TMR8_DIV8_MASK) == `TMR8_DIV8_MASK;
            TMR8_CLK_DIV64: tick_nxt = (div_r & `TMR8_DIV64_MASK) == `TMR8_DIV64_MASK;
            TMR8_CLK_DIV256: tick_nxt = (div_r & `TMR8_DIV256_MASK) == `TMR8_DIV256_MASK;
            TMR8_CLK_DIV1024: tick_nxt = div_r == `TMR8_DIV1024_MASK;
            default: tick_nxt = 1'b0;
        endcase
    end

    // Tick is a one-cycle enable on pclk, never a clock
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_r <= 10'h000;
            tick_r <= 1'b0;
        end else begin
            div_r <= div_r + 10'h001;
            tick_r <= tick_nxt;
        end
    end

    assign tick = tick_r;

endmodule
`default_nettype wire

// ==== verification/tmr8_pin_model.sv ====
// External circuitry on the compare pin: pad with a weak pull-down
`timescale 1ns/1ps
`default_nettype none

module tmr8_pin_model (
    input wire logic pin_out, // Value driven by the timer
    input wire logic pin_oe, // Timer drives the pad
    output logic pad // Level seen on the pad
);
    // Released pad settles at the pull-down level
    assign pad = pin_oe ? pin_out : 1'b0;
endmodule

`default_nettype wire

// ==== verification/tb_timer8_waveform_modes.sv ====
// Self-checking bench for the 8-bit waveform timer
`timescale 1ns/1ps
`default_nettype none
`include "tmr8_defs.svh"

module tb_timer8_waveform_modes import tmr8_pkg::*;;
    logic pclk, presetn, psel, penable, pwrite, ovf_ack, cmp_ack, err;
    logic pready, pslverr, ovf_flag, cmp_flag, pin_out, pin_oe, pad;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    int fails, tests_run;

    tmr8_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .ovf_ack(ovf_ack), .cmp_ack(cmp_ack),
        .ovf_flag(ovf_flag), .cmp_flag(cmp_flag), .pin_out(pin_out), .pin_oe(pin_oe));
    tmr8_pin_model pin (.pin_out(pin_out), .pin_oe(pin_oe), .pad(pad));

    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic check(input string name, input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            fails++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic summarize();
        if (fails == 0 && tests_run > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) begin
            fails++;
            summarize();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    function automatic logic [31:0] ctl(input logic f, input logic [2:0] cs,
        input logic [1:0] act, input logic [1:0] md);
        tmr8_ctrl_t c;
        c = '{f, cs, act, md};
        return {24'h0, c};
    endfunction

    task automatic wait_flag(input logic want_ovf);
        int n;
        n = 0;
        while ((want_ovf ? ovf_flag : cmp_flag) !== 1'b1 && n < 3000) begin
            @(negedge pclk);
            n++;
        end
        if (n >= 3000) begin
            fails++;
            summarize();
        end
    endtask

    task automatic setup(input logic [7:0] cnt, input logic [7:0] cmp);
        apb(1'b1, `TMR8_OFF_CTRL, 32'h0);
        apb(1'b1, `TMR8_OFF_COUNT, {24'h0, cnt});
        apb(1'b1, `TMR8_OFF_COMPARE, {24'h0, cmp});
        apb(1'b1, `TMR8_OFF_FLAGS, 32'h3);
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_reset();
        logic [11:0] offs[5] = '{`TMR8_OFF_CTRL, `TMR8_OFF_COUNT, `TMR8_OFF_COMPARE,
            `TMR8_OFF_FLAGS, `TMR8_OFF_PORT};
        foreach (offs[i]) begin
            apb(1'b0, offs[i], 32'h0);
            check("reset reg", rd, 32'h0);
        end
        check("reset pad", {31'h0, pad}, 32'h0);
        apb(1'b0, 12'h020, 32'h0);
        check("unmapped err", {31'h0, err}, 32'h1);
        check("unmapped data", rd, 32'h0);
    endtask

    task automatic t_force();
        apb(1'b1, `TMR8_OFF_PORT, 32'h2);
        apb(1'b1, `TMR8_OFF_CTRL, ctl(1'b1, 3'h0, 2'h3, 2'h0));
        apb(1'b0, `TMR8_OFF_CTRL, 32'h0);
        check("force reads zero", rd, 32'h0c);
        check("force set", {31'h0, pad}, 32'h1);
        apb(1'b1, `TMR8_OFF_CTRL, ctl(1'b1, 3'h0, 2'h2, 2'h0));
        apb(1'b0, `TMR8_OFF_FLAGS, 32'h0);
        check("force clear", {31'h0, pad}, 32'h0);
        apb(1'b1, `TMR8_OFF_CTRL, ctl(1'b1, 3'h0, 2'h3, 2'h0));
        apb(1'b1, `TMR8_OFF_CTRL, 32'h0);
        apb(1'b1, `TMR8_OFF_PORT, 32'h3);
        apb(1'b0, `TMR8_OFF_FLAGS, 32'h0);
        check("port value shown", {31'h0, pad}, 32'h1);
        apb(1'b1, `TMR8_OFF_PORT, 32'h2);
        apb(1'b0, `TMR8_OFF_FLAGS, 32'h0);
        check("port value low", {31'h0, pad}, 32'h0);
        apb(1'b1, `TMR8_OFF_CTRL, ctl(1'b0, 3'h0, 2'h3, 2'h0));
        apb(1'b1, `TMR8_OFF_PORT, 32'h1);
        apb(1'b0, `TMR8_OFF_FLAGS, 32'h0);
        check("input pin oe", {31'h0, pin_oe}, 32'h0);
        check("input pin pad", {31'h0, pad}, 32'h0);
        apb(1'b1, `TMR8_OFF_PORT, 32'h2);
        // Matches with action zero keep the preset level
        setup(8'h00, 8'h03);
        apb(1'b1, `TMR8_OFF_CTRL, ctl(1'b0, 3'h1, 2'h0, 2'h2));
        wait_flag(1'b0);
        // Stop with action zero first: one more tick follows a stop
        apb(1'b1, `TMR8_OFF_CTRL, ctl(1'b0, 3'h0, 2'h0, 2'h2));
        apb(1'b1, `TMR8_OFF_CTRL, ctl(1'b0, 3'h0, 2'h2, 2'h2));
        apb(1'b0, `TMR8_OFF_FLAGS, 32'h0);
        check("action zero hold", {31'h0, pad}, 32'h1);
        apb(1'b1, `TMR8_OFF_FLAGS, 32'h2);
        apb(1'b1, `TMR8_OFF_CTRL, ctl(1'b0, 3'h1, 2'h2, 2'h2));
        wait_flag(1'b0);
        apb(1'b1, `TMR8_OFF_CTRL, 32'h0);
        check("clear on match", {31'h0, pad}, 32'h0);
    endtask

    task automatic t_normal();
        setup(8'hfc, 8'h80);
        apb(1'b1, `TMR8_OFF_CTRL, ctl(1'b0, 3'h2, 2'h0, 2'h0));
        wait_flag(1'b1);
        apb(1'b1, `TMR8_OFF_CTRL, 32'h0);
        apb(1'b0, `TMR8_OFF_COUNT, 32'h0);
        check("wrap count", rd, 32'h0);
        apb(1'b1, `TMR8_OFF_FLAGS, 32'h1);
        apb(1'b0, `TMR8_OFF_FLAGS, 32'h0);
        check("flag w1c", rd, 32'h0);
    endtask

    task automatic t_ctc();
        // Top of one at div 8: a single match up to the stop, and no trailing tick
        setup(8'h00, 8'h01);
        apb(1'b1, `TMR8_OFF_CTRL, ctl(1'b0, 3'h2, 2'h1, 2'h2));
        wait_flag(1'b0);
        apb(1'b1, `TMR8_OFF_CTRL, ctl(1'b0, 3'h0, 2'h1, 2'h2));
        apb(1'b0, `TMR8_OFF_COUNT, 32'h0);
        check("ctc cleared", rd, 32'h0);
        check("ctc toggle", {31'h0, pad}, 32'h1);
        @(posedge pclk);
        cmp_ack <= 1'b1;
        @(posedge pclk);
        cmp_ack <= 1'b0;
        @(negedge pclk);
        check("cmp ack", {31'h0, cmp_flag}, 32'h0);
        setup(8'h10, 8'h05);
        apb(1'b1, `TMR8_OFF_CTRL, ctl(1'b0, 3'h1, 2'h0, 2'h2));
        wait_flag(1'b1);
        check("missed match", {31'h0, cmp_flag}, 32'h0);
        wait_flag(1'b0);
        @(posedge pclk);
        ovf_ack <= 1'b1;
        @(posedge pclk);
        ovf_ack <= 1'b0;
        @(negedge pclk);
        check("ovf ack", {31'h0, ovf_flag}, 32'h0);
    endtask

    task automatic t_prescale();
        int nd[5] = '{1, 8, 64, 256, 1024};
        logic [7:0] c0;
        foreach (nd[i]) begin
            apb(1'b1, `TMR8_OFF_CTRL, ctl(1'b0, 3'(i + 1), 2'h0, 2'h0));
            repeat (20) @(posedge pclk);
            apb(1'b0, `TMR8_OFF_COUNT, 32'h0);
            c0 = rd[7:0];
            repeat (4 * nd[i] - 3) @(posedge pclk);
            apb(1'b0, `TMR8_OFF_COUNT, 32'h0);
            check("ticks per window", {24'h0, rd[7:0] - c0}, 32'h4);
        end
    endtask

    task automatic t_fast();
        int hi;
        setup(8'h00, 8'h80);
        for (int act = 2; act <= 3; act++) begin
            apb(1'b1, `TMR8_OFF_CTRL, ctl(1'b0, 3'h1, 2'(act), 2'h3));
            apb(1'b1, `TMR8_OFF_FLAGS, 32'h1);
            wait_flag(1'b1);
            apb(1'b1, `TMR8_OFF_FLAGS, 32'h1);
            wait_flag(1'b1);
            hi = 0;
            repeat (256) begin
                @(negedge pclk);
                hi += int'(pad === 1'b1);
            end
            check("pwm high cycles", 32'(hi), (act == 2) ? 32'd129 : 32'd127);
        end
        apb(1'b1, `TMR8_OFF_CTRL, 32'h0);
    endtask

    task automatic t_midreset();
        apb(1'b1, `TMR8_OFF_PORT, 32'h2);
        apb(1'b1, `TMR8_OFF_CTRL, ctl(1'b1, 3'h0, 2'h3, 2'h0));
        apb(1'b0, `TMR8_OFF_FLAGS, 32'h0);
        check("preset before reset", {31'h0, pad}, 32'h1);
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        check("oe after reset", {31'h0, pin_oe}, 32'h0);
        apb(1'b1, `TMR8_OFF_PORT, 32'h2);
        apb(1'b1, `TMR8_OFF_CTRL, ctl(1'b0, 3'h0, 2'h3, 2'h0));
        apb(1'b0, `TMR8_OFF_FLAGS, 32'h0);
        check("output bit reset", {31'h0, pad}, 32'h0);
    endtask

    initial begin
        fails = 0;
        tests_run = 0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        ovf_ack = 1'b0;
        cmp_ack = 1'b0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_force();
        t_normal();
        t_ctc();
        t_prescale();
        t_fast();
        t_midreset();
        summarize();
    end
endmodule

`default_nettype wire
